// ===== cfc_core.sv
// fault confinement counters, bus-off recovery, center 15 shadow buffer
// assumes a bit engine that delivers one-cycle event pulses synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
`include "cfc_params.svh"

// What this block does
// - without overwrite enable, the overwrite flag never sets.
// - empty center takes message directly, occupied center sends it to shadow.
// - when data-updated and xreq are both clear, unread shadow contents move into the center.
// - overwrite enabled and occupied: shadow replaced, overwrite flag set.
// - overwrite flag sets on every shadow store while overwrite is enabled.
// - overwrite disabled, occupied and shadow full: incoming message dropped.
// - counters always readable; writing transmit counter loads both.
// - counters clear on system reset or module reset bit.
// - nap and power-down bits leave counters untouched.
// - receiver error adds one, except bit error in active/overload flag.
// - dominant first bit after flag, or flag bit error, adds eight to receive.
// - transmitted error flag adds eight, except the two exempt cases.
// - transmitter bit error in active/overload flag adds eight.
// - long dominant runs add eight to both counters.
// - successful transmission decrements transmit counter unless zero.
// - successful reception decrements 1..127, above 127 sets 119..127.
// - passive at 128 or more, active at 127 or less; receive stops above 128.
// - transmit counter 256 or more means bus off; receive counter cleared.
// - bus off counts 11-recessive-bit runs; 128 completes recovery.
// - recovery returns bus on, sets software init, clears the overwrite flag and counters.
// - timing registers load into engine on software init falling.
module cfc_core #(
   parameter int MSG_W = 64
) (
   input  wire logic                  mclk_i,
   input  wire logic                  reset_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   input  wire cfc_pkg::cfc_event_type ev_i,
   input  wire logic                  rx_valid_i,
   input  wire logic [MSG_W-1:0]      rx_msg_i,
   output logic      [15:0]           timing_o,
   output logic                       passive_o,
   output logic                       busoff_o
);
   // ====================================================================
   // state
   cfc_pkg::cfc_regs_type r;
   cfc_pkg::cfc_regs_type next_r;

   logic occupied;
   logic [9:0] tec_up;
   logic [9:0] rec_up;
   logic [8:0] tec_new;
   logic [8:0] rec_new;
   cfc_pkg::cfc_state_type next_st;
   logic ovw_set; // overwrite flag raised by hardware this cycle

   assign occupied = r.data_updated_flag | r.xreq;

   // ====================================================================
   // next-state logic
   always_comb begin
      next_r = r;
      next_r.rdata = 32'h0000_0000;
      ovw_set = 1'b0;
      tec_up = {1'b0, r.tec};
      rec_up = {1'b0, r.rec};
      if (ev_i.rx_err && !ev_i.rx_flag_bit) begin
         rec_up = rec_up + 10'd1;
      end
      if (ev_i.rx_dom_first || ev_i.rx_flag_bit) begin
         rec_up = rec_up + 10'd8;
      end
      if (ev_i.tx_flag && !ev_i.tx_exempt) begin
         tec_up = tec_up + 10'd8;
      end
      if (ev_i.tx_flag_bit) begin
         tec_up = tec_up + 10'd8;
      end
      if (ev_i.dom_run8) begin
         tec_up = tec_up + 10'd8;
         rec_up = rec_up + 10'd8;
      end
      if (ev_i.tx_ok && tec_up != 10'd0) begin
         tec_up = tec_up - 10'd1;
      end
      if (ev_i.rx_ok) begin
         if (r.rec > `CFC_ACTIVE_MAX) begin
            rec_up = {1'b0, `CFC_RX_REFILL};
         end else if (r.rec != 9'd0) begin
            rec_up = rec_up - 10'd1;
         end
      end
      // receive counter freezes once past the passive limit
      if (r.rec > `CFC_PASSIVE_LIM && !ev_i.rx_ok) begin
         rec_up = {1'b0, r.rec};
      end
      tec_new = (tec_up > 10'd511) ? 9'h1ff : tec_up[8:0];
      rec_new = (rec_up > 10'd511) ? 9'h1ff : rec_up[8:0];

      next_st = r.st;
      if (r.st == cfc_pkg::CFC_BUSOFF) begin
         // count idle runs during bus off
         if (ev_i.idle11) begin
            next_r.rec = r.rec + 9'd1;
         end
         if (r.rec >= `CFC_RECOV_CNT) begin
            next_st = cfc_pkg::CFC_ACTIVE;
            next_r.tec = 9'd0;
            next_r.rec = 9'd0;
            next_r.swinit = 1'b1;
            next_r.ovw = 1'b0;
         end
      end else begin
         next_r.tec = tec_new;
         next_r.rec = rec_new;
         if (tec_up >= {1'b0, `CFC_BUSOFF_LIM}) begin
            next_st = cfc_pkg::CFC_BUSOFF;
            next_r.rec = 9'd0;
         end else if (tec_new >= `CFC_PASSIVE_LIM || rec_new >= `CFC_PASSIVE_LIM) begin
            next_st = cfc_pkg::CFC_PASSIVE;
         end else begin
            next_st = cfc_pkg::CFC_ACTIVE;
         end
      end
      next_r.st = next_st;
      // software clears the change flag; the set further down wins
      if (wr_i && addr_i == `CFC_ADDR_STATUS && wdata_i[`CFC_ST_CHANGE]) begin
         next_r.change = 1'b0;
      end

      // center 15 receive path
      next_r.stored = 1'b0;
      if (rx_valid_i) begin
         if (!occupied) begin
            next_r.mc_msg = rx_msg_i;
            next_r.data_updated_flag = 1'b1;
            next_r.stored = 1'b1;
         end else if (!r.shf) begin
            next_r.sh_msg = rx_msg_i;
            next_r.shf = 1'b1;
            next_r.stored = 1'b1;
            // overwrite enabled sets flag even on empty shadow
            if (r.owe) begin
               next_r.ovw = 1'b1;
               ovw_set = 1'b1;
            end
         end else if (r.owe) begin
            // replace shadow, flag only for shadow
            next_r.sh_msg = rx_msg_i;
            next_r.ovw = 1'b1;
            ovw_set = 1'b1;
            next_r.stored = 1'b1;
         end
      end

      // ====================================================================
      // register writes
      if (wr_i) begin
         case (addr_i)
            `CFC_ADDR_CTRL: begin
               next_r.rst_bit = wdata_i[`CFC_CTRL_RST];
               next_r.swinit  = wdata_i[`CFC_CTRL_SWINIT];
               // low-power bits do not reach the counters
               next_r.nap     = wdata_i[`CFC_CTRL_NAP];
               next_r.pdown   = wdata_i[`CFC_CTRL_PDOWN];
            end
            `CFC_ADDR_TXERR: begin
               next_r.tec = wdata_i[8:0];
               next_r.rec = wdata_i[8:0];
            end
            `CFC_ADDR_MC15: begin
               // software frees center; a same-cycle load wins
               // only a direct load beats the clear; a shadow load leaves it in force
               if (!(next_r.stored && !occupied)) begin
                  next_r.data_updated_flag = wdata_i[`CFC_MC_DATA_UPDATED_FLAG] & r.data_updated_flag;
               end
               next_r.xreq = wdata_i[`CFC_MC_XREQ];
               next_r.owe  = wdata_i[`CFC_MC_OWE];
               // a fresh overwrite is never lost to a same-cycle clear
               if (!wdata_i[`CFC_MC_OVW] && !ovw_set) begin
                  next_r.ovw = 1'b0;
               end
            end
            `CFC_ADDR_TIMING: begin
               // timing editable only during software init
               if (r.swinit) begin
                  next_r.timing = wdata_i[15:0];
               end
            end
            default: begin
            end
         endcase
      end
      // refill center from shadow once it empties
      // works on the next shadow so a message landing this cycle is not dropped
      if (!next_r.data_updated_flag && !next_r.xreq && next_r.shf) begin
         next_r.mc_msg = next_r.sh_msg;
         next_r.data_updated_flag = 1'b1;
         next_r.shf = 1'b0;
      end
      // engine takes timing on software init falling
      if (r.swinit && !next_r.swinit) begin
         next_r.timing_live = r.timing;
      end
      if (r.rst_bit) begin
         next_r.tec = 9'd0;
         next_r.rec = 9'd0;
         next_r.st = cfc_pkg::CFC_ACTIVE;
      end
      // passive or active follows the counters as they will stand
      // so a counter write or module reset moves the state in the same edge
      if (next_r.st != cfc_pkg::CFC_BUSOFF) begin
         if (next_r.tec >= `CFC_PASSIVE_LIM || next_r.rec >= `CFC_PASSIVE_LIM) begin
            next_r.st = cfc_pkg::CFC_PASSIVE;
         end else begin
            next_r.st = cfc_pkg::CFC_ACTIVE;
         end
      end
      // any state change latches the event, beating a clear
      if (next_r.st != r.st) begin
         next_r.change = 1'b1;
      end
      // state pins come straight from flops, no decode after the register
      next_r.passive = (next_r.st == cfc_pkg::CFC_PASSIVE);
      next_r.busoff  = (next_r.st == cfc_pkg::CFC_BUSOFF);

      // ====================================================================
      // read mux, data one cycle later
      if (rd_i) begin
         case (addr_i)
            `CFC_ADDR_CTRL:   next_r.rdata = {28'h0, r.pdown, r.nap, r.swinit, r.rst_bit};
            `CFC_ADDR_TXERR:  next_r.rdata = {23'h0, r.tec};
            `CFC_ADDR_RXERR:  next_r.rdata = {23'h0, r.rec};
            `CFC_ADDR_STATUS: next_r.rdata = {29'h0, r.change,
                                              r.st == cfc_pkg::CFC_BUSOFF,
                                              r.st == cfc_pkg::CFC_PASSIVE};
            `CFC_ADDR_MC15:   next_r.rdata = {27'h0, r.shf, r.ovw, r.owe, r.xreq, r.data_updated_flag};
            `CFC_ADDR_TIMING: next_r.rdata = {16'h0, r.timing};
            `CFC_ADDR_MSGLO:  next_r.rdata = r.mc_msg[31:0];
            `CFC_ADDR_MSGHI:  next_r.rdata = r.mc_msg[63:32];
            default:          next_r.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ====================================================================
   // state register
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o   = r.rdata;
   assign timing_o  = r.timing_live;
   assign passive_o = r.passive;
   assign busoff_o  = r.busoff;

   // ====================================================================
   // checks
   chk_busoff_entry: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && !r.rst_bit && !wr_i && tec_up >= 10'd256)
      |=> (busoff_o && r.rec == 9'd0)) else $error("bus off not entered");
   chk_passive_lim: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && (r.tec >= 9'd128 || r.rec >= 9'd128)) |-> passive_o)
      else $error("passive state missing");
   chk_recovery: assert property (@(posedge mclk_i) disable iff (reset_i)
      (busoff_o && r.rec >= 9'd128 && !r.rst_bit && !wr_i)
      |=> (!busoff_o && r.swinit && r.tec == 9'd0)) else $error("recovery incomplete");
   chk_idle_count: assert property (@(posedge mclk_i) disable iff (reset_i)
      (busoff_o && ev_i.idle11 && r.rec < 9'd128 && !wr_i && !r.rst_bit)
      |=> r.rec == $past(r.rec) + 9'd1) else $error("idle run not counted");
   chk_no_ovw: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!r.owe && !r.ovw && !wr_i) |=> !r.ovw) else $error("overwrite flag without enable");
   chk_direct_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      (rx_valid_i && !occupied && !wr_i) |=> (r.data_updated_flag && r.mc_msg == $past(rx_msg_i)))
      else $error("direct load missed");
   chk_discard: assert property (@(posedge mclk_i) disable iff (reset_i)
      (rx_valid_i && occupied && r.shf && !r.owe && !wr_i) |=> $stable(r.sh_msg))
      else $error("message not discarded");
   chk_both_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr_i && addr_i == 8'h04 && !r.rst_bit && r.st != cfc_pkg::CFC_BUSOFF)
      |=> r.tec == r.rec) else $error("counter write not mirrored");
   chk_mod_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
      r.rst_bit |=> (r.tec == 9'd0 && r.rec == 9'd0)) else $error("module reset ignored");
   chk_timing_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.swinit && !next_r.swinit) |=> timing_o == $past(r.timing))
      else $error("timing not loaded");
   cov_busoff:   cover property (@(posedge mclk_i) disable iff (reset_i) $rose(busoff_o));
   cov_recover:  cover property (@(posedge mclk_i) disable iff (reset_i) $fell(busoff_o));
   cov_shadow:   cover property (@(posedge mclk_i) disable iff (reset_i) $rose(r.shf));
   cov_overwrite:cover property (@(posedge mclk_i) disable iff (reset_i) $rose(r.ovw));
   cov_xreq_shadow: cover property (@(posedge mclk_i) disable iff (reset_i) r.xreq && $rose(r.shf));

   // ====================================================================
   // single-event counter steps, center 15 bookkeeping and the state change flag
   chk_rx_err: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && ev_i == 10'h200 && r.rec <= 9'd128 && !wr_i && !r.rst_bit)
      |=> r.rec == $past(r.rec) + 9'd1) else $error("receive error not counted");
   chk_rx_dom: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && ev_i == 10'h080 && r.rec <= 9'd128 && !wr_i && !r.rst_bit)
      |=> r.rec == $past(r.rec) + 9'd8) else $error("dominant first bit not counted");
   chk_tx_ok: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && ev_i == 10'h004 && r.tec != 9'd0 && !wr_i && !r.rst_bit)
      |=> r.tec == $past(r.tec) - 9'd1) else $error("transmit success not counted");
   chk_rx_refill: assert property (@(posedge mclk_i) disable iff (reset_i)
      (r.st != cfc_pkg::CFC_BUSOFF && ev_i.rx_ok && r.rec > 9'd127 && tec_up < 10'd256
       && !wr_i && !r.rst_bit) |=> (r.rec >= 9'd119 && r.rec <= 9'd127))
      else $error("receive counter not refilled");
   chk_shadow_ovw: assert property (@(posedge mclk_i) disable iff (reset_i)
      (rx_valid_i && occupied && r.owe && !wr_i)
      |=> (r.ovw && r.shf && r.sh_msg == $past(rx_msg_i))) else $error("shadow not overwritten");
   chk_shadow_refill: assert property (@(posedge mclk_i) disable iff (reset_i)
      r.shf |-> (r.data_updated_flag || r.xreq)) else $error("empty center left beside full shadow");
   chk_change_set: assert property (@(posedge mclk_i) disable iff (reset_i)
      $changed(r.st) |-> r.change) else $error("state change not flagged");
endmodule : cfc_core
`default_nettype wire

// ===== cfc_far_node.sv
// far-side node model: bit-engine event pulses and received frames
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`default_nettype none
module cfc_far_node (
   input  wire logic                    mclk_i,
   output var  cfc_pkg::cfc_event_type  ev_o,
   output var  logic                    rx_valid_o,
   output var  logic [63:0]             rx_msg_o
);
   // ====================================================================
   // idle levels
   initial begin
      ev_o       = '0;
      rx_valid_o = 1'b0;
      rx_msg_o   = 64'h0;
   end

   // one event for exactly one cycle; code 4 is a flag with exemption
   task automatic fire(input int c);
      logic [9:0] v;
      v = (c == 4) ? 10'h060 : (c == 10) ? 10'h001 : 10'h200 >> c;
      @(posedge mclk_i);
      ev_o <= cfc_pkg::cfc_event_type'(v);
      @(posedge mclk_i);
      ev_o <= '0;
   endtask : fire

   // frame pulse; the data lines then lose the old value
   task automatic send(input logic [63:0] m);
      @(posedge mclk_i);
      rx_valid_o <= 1'b1;
      rx_msg_o   <= m;
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_msg_o   <= ~m;
   endtask : send
endmodule : cfc_far_node
`default_nettype wire

// ===== cfc_params.svh
// constants for the fault-confinement and center-15 shadow block
// assumes inclusion by the core module and the top module only
`ifndef CFC_PARAMS_SVH
`define CFC_PARAMS_SVH
// ====================================================================
// register offsets
`define CFC_ADDR_CTRL     8'h00
`define CFC_ADDR_TXERR    8'h04
`define CFC_ADDR_RXERR    8'h08
`define CFC_ADDR_STATUS   8'h0c
`define CFC_ADDR_MC15     8'h10
`define CFC_ADDR_TIMING   8'h14
`define CFC_ADDR_MSGLO    8'h18
`define CFC_ADDR_MSGHI    8'h1c
// ctrl fields
`define CFC_CTRL_RST      0
`define CFC_CTRL_SWINIT   1
`define CFC_CTRL_NAP      2
`define CFC_CTRL_PDOWN    3
// center 15 fields
`define CFC_MC_DATA_UPDATED_FLAG       0
`define CFC_MC_XREQ       1
`define CFC_MC_OWE        2
`define CFC_MC_OVW        3
`define CFC_MC_SHF        4
// status fields
`define CFC_ST_PASSIVE    0
`define CFC_ST_BUSOFF     1
`define CFC_ST_CHANGE     2
// counter figures
`define CFC_PASSIVE_LIM   9'd128
`define CFC_ACTIVE_MAX    9'd127
`define CFC_RX_REFILL     9'd120
`define CFC_BUSOFF_LIM    9'd256
`define CFC_RECOV_CNT     9'd128
`define CFC_IDLE_BITS     4'd11
`define CFC_RESET_TIMING  16'h0000
`endif

// ===== cfc_pkg.sv
// types for the fault-confinement block
// assumes cfc_params.svh sits in the same folder
package cfc_pkg;
   // ====================================================================
   // confinement states
   typedef enum logic [1:0] {
      CFC_ACTIVE  = 2'b00,
      CFC_PASSIVE = 2'b01,
      CFC_BUSOFF  = 2'b10
   } cfc_state_type;

   // bus-side events from the bit engine, one-cycle pulses
   typedef struct packed {
      logic rx_err;      // receiver error seen
      logic rx_flag_bit; // bit error while sending active/overload flag (rx)
      logic rx_dom_first;// dominant bit right after own error flag
      logic tx_flag;     // transmitter sent an error flag
      logic tx_exempt;   // passive ack error or arbitration stuff error
      logic tx_flag_bit; // bit error while sending active/overload flag (tx)
      logic dom_run8;    // 14th / 8th / further-8 dominant bit reached
      logic tx_ok;       // successful transmission
      logic rx_ok;       // successful reception
      logic idle11;      // 11 consecutive recessive bits seen
   } cfc_event_type;

   // whole module state
   typedef struct packed {
      logic [8:0]    tec;
      logic [8:0]    rec;
      cfc_state_type st;
      logic          change;
      logic          rst_bit;
      logic          swinit;
      logic          nap;
      logic          pdown;
      logic          data_updated_flag;
      logic          xreq;
      logic          owe;
      logic          ovw;
      logic          shf;
      logic [63:0]   mc_msg;
      logic [63:0]   sh_msg;
      logic [15:0]   timing;
      logic [15:0]   timing_live;
      logic          stored;
      logic [31:0]   rdata;
      logic          passive;    // registered copy of the passive state
      logic          busoff;     // registered copy of the bus-off state
   } cfc_regs_type;
endpackage : cfc_pkg

// ===== testbench.sv
// self-checking bench for the fault-confinement and center-15 block
// assumes cfc_pkg, cfc_core and cfc_far_node are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cfc_params.svh"
module testbench;
   logic                   mclk_i;
   logic                   reset_i;
   logic [7:0]             addr_i;
   logic [31:0]            wdata_i;
   logic                   wr_i;
   logic                   rd_i;
   logic [31:0]            rdata_o;
   logic [15:0]            timing_o;
   logic                   passive_o;
   logic                   busoff_o;
   logic                   rx_valid;
   logic [63:0]            rx_msg;
   cfc_pkg::cfc_event_type ev;
   int                     error_cnt;
   int                     tests_run;
   int                     tec;
   int                     rec;
   bit                     boff;
   bit                     m_data_updated_flag;
   bit                     m_shf;
   bit                     m_ovw;
   bit                     m_owe;
   bit                     m_xreq;
   bit                     chg;
   logic [1:0]             mst;
   logic [63:0]            m_msg;
   logic [63:0]            m_sh;
   logic [15:0]            seed;
   logic [31:0]            d;

   cfc_core dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_i(ev), .rx_valid_i(rx_valid),
      .rx_msg_i(rx_msg), .timing_o(timing_o), .passive_o(passive_o), .busoff_o(busoff_o));
   cfc_far_node node (.mclk_i(mclk_i), .ev_o(ev), .rx_valid_o(rx_valid), .rx_msg_o(rx_msg));

   // ====================================================================
   // clock and helpers
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask : bus_wr

   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a);
      @(posedge mclk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask : bus_rd

   // ====================================================================
   // counter model, one event per call
   task automatic apply(input int c);
      bit up;
      up = (rec <= 128); // frozen above the passive limit
      case (c)
         0: if (up) rec += 1;
         1, 2: if (up) rec += 8;
         3, 5: tec += 8;
         6: begin
            tec += 8;
            if (up) rec += 8;
         end
         7: if (tec > 0) tec -= 1;
         8: rec = (rec > 127) ? 120 : (rec > 0) ? rec - 1 : 0;
         10: rec += 1;
         default: ;
      endcase
      if (tec >= 256 && !boff) begin
         boff = 1'b1;
         rec  = 0;
      end
      if (boff && rec >= 128) begin
         boff = 1'b0;
         tec  = 0;
         rec  = 0;
      end
   endtask : apply

   // settle, then compare the rx counter, the tx counter outside bus off, status and state pins
   task automatic cnt_chk();
      logic [31:0] s;
      s = {30'h0, boff, !boff && (tec >= 128 || rec >= 128)};
      if (s[1:0] != mst) chg = 1'b1; // any state change is latched
      mst  = s[1:0];
      s[2] = chg;
      repeat (2) @(posedge mclk_i);
      bus_rd(`CFC_ADDR_RXERR);
      chk("rx counter", rec, d);
      if (!boff) begin
         bus_rd(`CFC_ADDR_TXERR);
         chk("tx counter", tec, d);
      end
      bus_rd(`CFC_ADDR_STATUS);
      chk("status", s, {29'h0, d[2:0]});
      chk("state pins", {30'h0, s[1:0]}, {30'h0, busoff_o, passive_o});
      if (chg) begin
         bus_wr(`CFC_ADDR_STATUS, 32'h4);
         chg = 1'b0;
      end
   endtask : cnt_chk

   // code 9 writes the tx counter, the others are bus events
   task automatic step(input int c, input logic [7:0] v);
      bit was;
      was = boff;
      if (c == 9) begin
         bus_wr(`CFC_ADDR_TXERR, {24'h0, v});
         tec = v;
         rec = v;
      end else begin
         node.fire(c);
         apply(c);
      end
      cnt_chk();
      if (was && !boff) begin
         bus_rd(`CFC_ADDR_CTRL);
         chk("soft init", 32'h1, {31'h0, d[`CFC_CTRL_SWINIT]});
      end
   endtask : step

   // ====================================================================
   // center 15 model
   task automatic mc_chk();
      repeat (2) @(posedge mclk_i);
      bus_rd(`CFC_ADDR_MC15);
      chk("center flags", {27'h0, m_shf, m_ovw, m_owe, m_xreq, m_data_updated_flag}, {27'h0, d[4:0]});
      bus_rd(`CFC_ADDR_MSGLO);
      chk("message low", m_msg[31:0], d);
      bus_rd(`CFC_ADDR_MSGHI);
      chk("message high", m_msg[63:32], d);
   endtask : mc_chk

   task automatic deliver();
      logic [63:0] m;
      seed = lfsr(seed);
      m    = {seed, ~seed, seed ^ 16'h3c3c, lfsr(seed)};
      node.send(m);
      if (!m_data_updated_flag && !m_xreq) begin
         m_msg  = m;
         m_data_updated_flag = 1'b1;
      end else if (!m_shf || m_owe) begin
         m_sh  = m;
         m_shf = 1'b1;
         m_ovw = m_ovw | m_owe;
      end
      mc_chk();
   endtask : deliver

   // overwrite flag written 0; a freed center refills from the shadow
   task automatic mc_wr(input bit data_updated_flag, input bit xreq, input bit owe);
      bus_wr(`CFC_ADDR_MC15, {29'h0, owe, xreq, data_updated_flag});
      m_owe  = owe;
      m_ovw  = 1'b0;
      m_xreq = xreq;
      if (!data_updated_flag) m_data_updated_flag = 1'b0;
      if (!m_data_updated_flag && !m_xreq && m_shf) begin
         m_msg  = m_sh;
         m_data_updated_flag = 1'b1;
         m_shf  = 1'b0;
      end
      mc_chk();
   endtask : mc_wr

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   // ====================================================================
   // watchdog, well past the expected few thousand cycles
   initial begin
      repeat (60000) @(posedge mclk_i);
      error_cnt++;
      end_of_test();
   end

   // ====================================================================
   // main sequence
   initial begin
      {reset_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 40'h0};
      {error_cnt, tests_run, tec, rec, boff, chg, mst} = '0;
      {m_data_updated_flag, m_xreq, m_shf, m_ovw, m_owe, m_msg, m_sh} = '0;
      seed = 16'd6891;
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'b0;
      cnt_chk();
      $display("reset values done");
      bus_wr(`CFC_ADDR_CTRL, 32'h2);
      bus_wr(`CFC_ADDR_TIMING, {16'h0, seed});
      repeat (2) @(posedge mclk_i);
      chk("timing held", 32'h0, {16'h0, timing_o});
      bus_wr(`CFC_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge mclk_i);
      chk("timing loaded", {16'h0, seed}, {16'h0, timing_o});
      $display("timing load done");
      repeat (3) deliver();
      mc_wr(1'b0, 1'b0, 1'b0);
      mc_wr(1'b1, 1'b0, 1'b1);
      repeat (2) deliver();
      mc_wr(1'b0, 1'b0, 1'b1);
      mc_wr(1'b0, 1'b1, 1'b1);
      deliver();
      mc_wr(1'b0, 1'b0, 1'b1);
      $display("center 15 done");
      step(9, 8'd250);
      step(3, 8'd0);
      repeat (128) step(10, 8'd0);
      $display("bus off recovery done");
      repeat (200) begin
         seed = lfsr(seed);
         step(boff ? 10 : int'(seed % 16'd10), seed[15:8]);
      end
      $display("random events done");
      bus_wr(`CFC_ADDR_CTRL, 32'hc);
      bus_wr(`CFC_ADDR_CTRL, 32'h0);
      cnt_chk();
      bus_wr(`CFC_ADDR_CTRL, 32'h1);
      bus_wr(`CFC_ADDR_CTRL, 32'h0);
      {tec, rec, boff} = '0;
      cnt_chk();
      $display("low power and module reset done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
